// ==== core/led_fade_ctrl.sv ====
// two-channel led fade, short, clamp and thermal control logic
`timescale 1ns/1ps
module led_fade_ctrl
  import led_fade_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int PERSIST_CYCLES = PERSIST_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] channel_toggle_input_n,
  input wire logic [1:0] short_detect_threshold,
  input wire logic current_program_short,
  input wire logic [9:0] current_program_pin,
  input wire logic [7:0] fade_time_pin,
  input wire logic [7:0] die_temp,
  output logic [9:0] channel_current_output_0,
  output logic [9:0] channel_current_output_1,
  output logic [1:0] short_fault,
  output logic thermal_block
);

  // level scaled by a current, thousandths back to milliamps
  function automatic logic [9:0] scale_level(input logic [9:0] lvl,
                                             input logic [9:0] ma);
    logic [19:0] prod;
    prod = 20'(lvl) * 20'(ma);
    return 10'(prod / 20'd1000);
  endfunction : scale_level

  // percentage of a current
  function automatic logic [9:0] pct_of(input logic [9:0] ma,
                                        input logic [6:0] pct);
    logic [16:0] prod;
    prod = 17'(ma) * 17'(pct);
    return 10'(prod / 17'd100);
  endfunction : pct_of

  // two-flop synchronisers for pin level inputs
  logic [1:0] tog_m, tog_s, sh_m, sh_s;
  logic current_program_pin_m, current_program_pin_s;
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_m <= 2'h3;
      tog_s <= 2'h3;
      sh_m <= 2'h0;
      sh_s <= 2'h0;
      current_program_pin_m <= 1'b0;
      current_program_pin_s <= 1'b0;
    end else begin
      tog_m <= channel_toggle_input_n;
      tog_s <= tog_m;
      sh_m <= short_detect_threshold;
      sh_s <= sh_m;
      current_program_pin_m <= current_program_short;
      current_program_pin_s <= current_program_pin_m;
    end
  end

  chan_state_t state [2], next_state [2];
  logic [5:0] idx [2], next_idx [2];
  logic [19:0] step_cnt [2], next_step_cnt [2];
  logic [19:0] deb_cnt [2], next_deb_cnt [2];
  logic [19:0] per_cnt [2], next_per_cnt [2];
  logic [1:0] deb, next_deb, next_fault;
  logic [9:0] next_out [2];
  logic next_block;
  logic [19:0] interval;
  logic hot, cool;
  logic [9:0] set_ma, lvl_ma, cut_ma;
  logic [7:0] over;
  logic [6:0] roll_pct;
  logic press;
  logic tick;

  assign hot = die_temp > SHUTDOWN_C;
  assign cool = die_temp < RECOVER_C;
  // evenly spaced steps; zero on the fade pin means a step every cycle
  assign interval = 20'(fade_time_pin) * 20'(STEP_UNIT_CYC);

  // per-channel debounce, fault qualification and fade sequencing
  always_comb begin
    next_block = hot || (thermal_block && !cool);
    set_ma = current_program_pin_s ? CURRENT_PROGRAM_PIN_LIMIT_MA : current_program_pin;
    over = die_temp - ROLLOFF_C;
    if (die_temp <= ROLLOFF_C) begin
      roll_pct = FULL_PCT;
    end else if (over >= 8'd34) begin
      roll_pct = 7'h00;
    end else begin
      roll_pct = FULL_PCT - 7'(over * ROLL_SLOPE_PCT);
    end
    press = 1'b0;
    tick = 1'b0;
    lvl_ma = 10'h000;
    cut_ma = 10'h000;
    for (int c = 0; c < 2; c++) begin
      next_state[c] = state[c];
      next_idx[c] = idx[c];
      next_step_cnt[c] = step_cnt[c];
      next_deb[c] = deb[c];
      next_deb_cnt[c] = 20'h00000;
      next_per_cnt[c] = 20'h00000;
      next_fault[c] = 1'b0;
      press = 1'b0;
      // both edges must hold for the full debounce time
      if (tog_s[c] != deb[c]) begin
        if (deb_cnt[c] == 20'(DEBOUNCE_CYCLES - 1)) begin
          next_deb[c] = tog_s[c];
          press = !tog_s[c];
        end else begin
          next_deb_cnt[c] = deb_cnt[c] + 20'h00001;
        end
      end
      // persistence counter restarts on any drop of the flag
      if (sh_s[c]) begin
        if (short_fault[c] ||
            per_cnt[c] == 20'(PERSIST_CYCLES - 1)) begin
          next_fault[c] = 1'b1;
        end else begin
          next_per_cnt[c] = per_cnt[c] + 20'h00001;
        end
      end
      tick = (step_cnt[c] >= interval);
      if (state[c] == CH_FADE_IN || state[c] == CH_FADE_OUT) begin
        next_step_cnt[c] = tick ? 20'h00000 : step_cnt[c] + 20'h00001;
      end
      case (state[c])
        CH_OFF: begin
          if (press && !next_block) begin
            next_state[c] = CH_FADE_IN;
            next_step_cnt[c] = 20'h00000;
          end
        end
        CH_FADE_IN: begin
          if (press) begin
            next_state[c] = CH_FADE_OUT;
            next_step_cnt[c] = 20'h00000;
          end else if (tick) begin
            // a reversed fade may start at the top, so never step past it
            if (idx[c] >= GAMMA_TOP - 6'h01) begin
              next_idx[c] = GAMMA_TOP;
              next_state[c] = CH_ON;
            end else begin
              next_idx[c] = idx[c] + 6'h01;
            end
          end
        end
        CH_ON: begin
          if (press) begin
            next_state[c] = CH_FADE_OUT;
            next_step_cnt[c] = 20'h00000;
          end
        end
        CH_FADE_OUT: begin
          if (press && !next_block) begin
            next_state[c] = CH_FADE_IN;
            next_step_cnt[c] = 20'h00000;
          end else if (tick) begin
            // a reversed fade may start at zero, so never wrap below it
            if (idx[c] <= 6'h01) begin
              next_idx[c] = 6'h00;
              next_state[c] = CH_OFF;
            end else begin
              next_idx[c] = idx[c] - 6'h01;
            end
          end
        end
        default: begin
          next_state[c] = CH_OFF;
          next_idx[c] = 6'h00;
        end
      endcase
      // shutdown forces the channel off whatever it was doing
      if (hot) begin
        next_state[c] = CH_OFF;
        next_idx[c] = 6'h00;
        next_step_cnt[c] = 20'h00000;
      end
      // the table is the only source of step size
      lvl_ma = scale_level(GAMMA[idx[c]], set_ma);
      cut_ma = pct_of(set_ma, SHORT_PCT);
      if (short_fault[c] && lvl_ma > cut_ma) begin
        lvl_ma = cut_ma;
      end
      next_out[c] = hot ? 10'h000 : pct_of(lvl_ma, roll_pct);
    end
  end

  // registers only; outputs come straight from these flops
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        state[c] <= CH_OFF;
        idx[c] <= 6'h00;
        step_cnt[c] <= 20'h00000;
        deb_cnt[c] <= 20'h00000;
        per_cnt[c] <= 20'h00000;
      end
      deb <= 2'h3;
      short_fault <= 2'h0;
      thermal_block <= 1'b0;
      channel_current_output_0 <= 10'h000;
      channel_current_output_1 <= 10'h000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        state[c] <= next_state[c];
        idx[c] <= next_idx[c];
        step_cnt[c] <= next_step_cnt[c];
        deb_cnt[c] <= next_deb_cnt[c];
        per_cnt[c] <= next_per_cnt[c];
      end
      deb <= next_deb;
      short_fault <= next_fault;
      thermal_block <= next_block;
      channel_current_output_0 <= next_out[0];
      channel_current_output_1 <= next_out[1];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_gamma_top: assert property (
    state[0] == CH_ON |-> idx[0] == GAMMA_TOP)
    else $error("channel on below the top gamma entry");
  a_gamma_grow: assert property (
    idx[0] > 6'h00 |-> GAMMA[idx[0]] >= GAMMA[idx[0] - 6'h01])
    else $error("gamma table not rising");
  a_short_qualify: assert property (
    $rose(short_fault[0]) |->
      $past(sh_s[0]) && $past(per_cnt[0]) == 20'(PERSIST_CYCLES - 1))
    else $error("short fault without persistence");
  a_short_cut: assert property (
    short_fault[0] && !hot && state[0] == CH_ON |=>
      channel_current_output_0 <= pct_of($past(set_ma), SHORT_PCT))
    else $error("shorted channel not cut");
  a_short_clear: assert property (
    !sh_s[0] |=> !short_fault[0])
    else $error("short fault kept after flag dropped");
  a_current_program_pin_clamp: assert property (
    current_program_pin_s |=> channel_current_output_0 <= CURRENT_PROGRAM_PIN_LIMIT_MA &&
      channel_current_output_1 <= CURRENT_PROGRAM_PIN_LIMIT_MA)
    else $error("shorted set pin not clamped");
  a_roll_zero: assert property (
    die_temp >= 8'd164 |=> channel_current_output_0 == 10'h000)
    else $error("roll-off did not reach zero");
  a_shutdown_off: assert property (
    hot |=> state[0] == CH_OFF && state[1] == CH_OFF &&
      channel_current_output_1 == 10'h000)
    else $error("channels not off in shutdown");
  a_restart_block: assert property (
    thermal_block && !cool && state[0] == CH_OFF |=> state[0] == CH_OFF)
    else $error("restart allowed before cooling");
  a_debounce_hold: assert property (
    $changed(deb[0]) |-> $past(deb_cnt[0]) == 20'(DEBOUNCE_CYCLES - 1))
    else $error("toggle accepted before debounce time");
  a_fade_dir: assert property (
    state[1] == CH_FADE_IN && !hot |=>
      idx[1] >= $past(idx[1]) || state[1] == CH_FADE_OUT)
    else $error("fade in moved downward");

endmodule : led_fade_ctrl

// ==== shared/led_fade_pkg.sv ====
// constants, types and gamma table for the two-channel led fade controller
package led_fade_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int GAMMA_STEPS = 63;
  localparam logic [5:0] GAMMA_TOP = 6'h3e;
  localparam logic [9:0] FULL_SCALE = 10'h3e8; // 1000 thousandths
  localparam int PERSIST_MS = 5;
  localparam int PERSIST_CYC = PERSIST_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_MS = 37;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  // fade_time_pin lsb is 10 ms of total fade, shared over 63 steps
  localparam int FADE_UNIT_US = 10000;
  localparam int STEP_UNIT_CYC = (FADE_UNIT_US * (CLK_HZ / 1000000))
                                 / GAMMA_STEPS;
  localparam logic [9:0] CURRENT_PROGRAM_PIN_LIMIT_MA = 10'h104; // 260 mA
  localparam logic [6:0] SHORT_PCT = 7'h14; // 20 percent
  localparam logic [6:0] FULL_PCT = 7'h64; // 100 percent
  localparam logic [7:0] ROLLOFF_C = 8'h82; // 130 C
  localparam logic [7:0] SHUTDOWN_C = 8'h9b; // 155 C
  localparam logic [7:0] RECOVER_C = 8'h87; // 135 C
  localparam logic [7:0] ROLL_SLOPE_PCT = 8'h03; // percent per C

  typedef enum logic [1:0] {
    CH_OFF, CH_FADE_IN, CH_ON, CH_FADE_OUT
  } chan_state_t;

  // gamma level table in thousandths of full current
  localparam logic [9:0] GAMMA [0:62] = '{
    10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
    10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
    10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
    10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
    10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
    10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
    10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
    10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000};
endpackage : led_fade_pkg

// ==== sim/tb_led_fade_ctrl.sv ====
// self-checking bench for the led fade controller
`timescale 1ns/1ps
module tb_led_fade_ctrl;
  import led_fade_pkg::*;
  logic clk, rst, cps, tblk;
  logic [1:0] tog_n, sdt, sf;
  logic [9:0] setp, out0, out1;
  logic [7:0] fade, temp;
  int bad_count, n_tests;
  logic [9:0] seen[$];

  toggle_switch sw (.clk(clk), .toggle_n(tog_n));
  // short counts keep the run brief
  led_fade_ctrl #(.DEBOUNCE_CYCLES(20), .PERSIST_CYCLES(10)) dut (
    .clk(clk), .rst(rst), .channel_toggle_input_n(tog_n),
    .short_detect_threshold(sdt), .current_program_short(cps),
    .current_program_pin(setp), .fade_time_pin(fade), .die_temp(temp),
    .channel_current_output_0(out0), .channel_current_output_1(out1),
    .short_fault(sf), .thermal_block(tblk));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // inputs change 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // log each new level on channel 0
  task automatic watch(input int n);
    seen = {out0};
    repeat (n) begin
      cyc(1);
      if (out0 !== seen[$]) seen.push_back(out0);
    end
  endtask : watch

  // set current 1000 mA makes the command equal the table level
  task automatic fade_ch0(input bit up);
    fork
      sw.press(0, 30);
      watch(150);
    join
    chk(seen.size(), 63);
    chk(seen[up ? 7 : 55], 16);
    chk(seen[31], 194);
    chk(seen[up ? 49 : 13], 534);
    chk(seen[up ? 62 : 0], 1000);
    chk(seen[up ? 0 : 62], 0);
    // step at the bright end must beat the step at the dark end
    chk((seen[up ? 62 : 0] - seen[up ? 61 : 1]) >
        (seen[up ? 1 : 61] - seen[up ? 0 : 62]), 1);
  endtask : fade_ch0

  task automatic t_start();
    chk(out0, 0);
    chk(out1, 0);
    sw.press(0, 5);
    chk(out0, 0);
    $display("start and glitch done");
  endtask : t_start

  task automatic t_fade();
    fade_ch0(1);
    fade_ch0(0);
    fade_ch0(1);
    sw.press(1, 30);
    cyc(60);
    chk(out1, 1000);
    $display("fade done");
  endtask : t_fade

  task automatic t_short();
    sdt = 2'h1;
    cyc(5);
    sdt = 2'h0;
    cyc(20);
    chk(sf, 0);
    sdt = 2'h1;
    cyc(20);
    chk(sf, 1);
    chk(out0, 200);
    chk(out1, 1000);
    sdt = 2'h0;
    cyc(10);
    chk(sf, 0);
    chk(out0, 1000);
    cps = 1'b1;
    cyc(10);
    chk(out1, 260);
    sdt = 2'h1;
    cyc(20);
    chk(out0, 52);
    sdt = 2'h0;
    cps = 1'b0;
    cyc(10);
    chk(out1, 1000);
    $display("short and clamp done");
  endtask : t_short

  task automatic t_heat();
    temp = 8'h8c;
    cyc(5);
    chk(out0, 700);
    chk(out1, 700);
    temp = 8'ha0;
    cyc(5);
    chk(out0, 0);
    chk(out1, 0);
    chk(tblk, 1);
    temp = 8'h8c;
    sw.press(0, 30);
    cyc(100);
    chk(out0, 0);
    temp = 8'h82;
    cyc(5);
    chk(tblk, 0);
    sw.press(0, 30);
    cyc(60);
    chk(out0, 1000);
    $display("thermal done");
  endtask : t_heat

  // one fade unit: first step only after a full interval, then reverse
  task automatic t_slow();
    fade = 8'h01;
    sw.press(1, 30);
    cyc(3000);
    chk(out1, 0);
    cyc(200);
    chk(out1, 2);
    sw.press(1, 30);
    cyc(3000);
    chk(out1, 2);
    cyc(200);
    chk(out1, 0);
    $display("slow fade done");
  endtask : t_slow

  // tests should end near 7500 cycles
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    sdt = 2'h0;
    cps = 1'b0;
    setp = 10'h3e8;
    fade = 8'h00;
    temp = 8'h19;
    bad_count = 0;
    n_tests = 0;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_start();
    t_fade();
    t_short();
    t_heat();
    t_slow();
    end_sim();
  end
endmodule : tb_led_fade_ctrl

// ==== sim/toggle_switch.sv ====
// momentary switch model driving the active-low toggle pins
`timescale 1ns/1ps
module toggle_switch (
  input wire logic clk,
  output logic [1:0] toggle_n
);
  // pins rest high through the pull-up
  initial begin
    toggle_n = 2'h3;
  end
  // hold one pin low, then release and let the release settle too
  task automatic press(input int ch, input int hold);
    @(posedge clk);
    #1 toggle_n[ch] = 1'b0;
    repeat (hold) @(posedge clk);
    #1 toggle_n[ch] = 1'b1;
    repeat (30) @(posedge clk); // release also debounces
    #1; // hand back off the edge so callers never race the flops
  endtask : press
endmodule : toggle_switch
